// ==== src/camd_decoder.sv ====
`default_nettype none
module camd_decoder #(
	parameter int ROM_KB = camd_pkg::ROM_KB_DEF,
	parameter int RAM_KB = camd_pkg::RAM_KB_DEF
) (
	input  wire logic                 sys_clk,
	input  wire logic                 srst,
	input  wire logic                 strap_select_low,
	input  wire logic                 strap_select_high,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic                 cpu_req_valid,
	input  wire camd_pkg::camd_req_t  cpu_req,
	output logic                      cpu_busy,
	output logic                      cpu_done,
	output logic                      cpu_fault,
	output logic      [31:0]          cpu_rdata,
	output logic      [31:0]          cpu_addr_view,
	output logic                      boot_valid,
	output logic      [31:0]          boot_addr,
	output camd_pkg::camd_mode_t      op_mode,
	output camd_pkg::camd_down_t      down,
	input  wire logic [15:0]          per_rdata,
	output logic [camd_pkg::NUM_CS-1:0] chip_sel_n,
	output logic                      ext_bus_enable
);
	localparam logic [27:0] ROM_TOP  = 28'(ROM_KB * camd_pkg::KB);
	localparam logic [27:0] RAM_BASE = 28'(camd_pkg::RAM_REGION_END + 28'h1
		- 28'(RAM_KB * camd_pkg::KB));

	typedef struct packed {
		camd_pkg::camd_fsm_t  st;
		camd_pkg::camd_mode_t mode;
		logic                 strap_done;
		logic                 busy;
		logic                 boot_valid;
		logic [31:0]          boot_addr;
		camd_pkg::camd_down_t down;
		logic [camd_pkg::NUM_CS-1:0] cs_n;
		logic                 done;
		logic                 fault;
		logic [31:0]          rdata;
		logic [31:0]          view;
		logic [15:0]          hi_wdata;
		logic [15:0]          lo_half;
		logic                 word_rd;
		logic                 byte_rd;
		logic                 hi_lane;
		logic                 narrow_rd;
		logic [15:0]          ctrl;
		logic [15:0]          csc_a;
		logic [15:0]          csc_b;
		logic                 fault_sticky;
		logic [31:0]          fault_addr;
		logic                 dp_valid;
		logic                 dp_wr;
		logic [7:0]           dp_ofs;
		logic [31:0]          hrdata;
		logic                 hreadyout;
	} camd_state_t;

	camd_state_t s_reg;
	camd_state_t s_next;

	////////////////////////////////////////////////////////////////////////////////
	function automatic camd_pkg::camd_tgt_t classify(input logic [27:0] p, input logic fetch);
		logic [15:0] page;
		page = p[27:camd_pkg::PAGE_LSB];
		if (page == camd_pkg::PERI_PAGE)
			return fetch ? camd_pkg::TGT_NONE : camd_pkg::TGT_PERI;
		if (page == camd_pkg::MIRROR_PAGE)
			return camd_pkg::TGT_NONE;
		if (p <= camd_pkg::ROM_REGION_END)
			return (p < ROM_TOP) ? camd_pkg::TGT_ROM : camd_pkg::TGT_NONE;
		if (p >= camd_pkg::RAM_REGION_BASE && p <= camd_pkg::RAM_REGION_END)
			return (p >= RAM_BASE) ? camd_pkg::TGT_RAM : camd_pkg::TGT_NONE;
		if (fetch && p >= camd_pkg::EXT_FETCH_LIMIT)
			return camd_pkg::TGT_NONE;
		return camd_pkg::TGT_EXT;
	endfunction

	// Block nibble picks the chip select
	function automatic logic [camd_pkg::NUM_CS-1:0] cs_of(input logic [27:0] p,
		input logic [15:0] a, input logic [15:0] b);
		logic [2:0]  blk;
		logic [31:0] both;
		logic [3:0]  nib;
		blk  = p[27:camd_pkg::CS_BLK_LSB];
		both = {b, a};
		nib  = both[blk*camd_pkg::CS_NIB_W +: camd_pkg::CS_NIB_W];
		return ~(camd_pkg::NUM_CS'(1) << nib[camd_pkg::CS_IDX_W-1:0]);
	endfunction

	function automatic logic [31:0] reg_read(input camd_state_t st, input logic [7:0] ofs);
		logic [31:0] r;
		r = 32'h0;
		unique case (ofs)
			camd_pkg::OFS_CTRL:       r = {16'h0, st.ctrl};
			camd_pkg::OFS_CSC_A:      r = {16'h0, st.csc_a};
			camd_pkg::OFS_CSC_B:      r = {16'h0, st.csc_b};
			camd_pkg::OFS_STATUS: begin
				r[1:0] = st.mode;
				r[camd_pkg::STAT_READY_BIT] = st.strap_done;
				r[camd_pkg::STAT_FAULT_BIT] = st.fault_sticky;
			end
			camd_pkg::OFS_FAULT_ADDR: r = st.fault_addr;
			default:                  r = 32'h0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic        acc_go;
	logic [31:0] a32;
	logic [27:0] phys;
	camd_pkg::camd_tgt_t tgt;
	logic        ahb_take;

	typedef logic [camd_pkg::PC_W-1:0] camd_pc_t;

	always_comb begin
		acc_go = cpu_req_valid && !s_reg.busy;
		if (cpu_req.fetch) begin
			a32 = {6'h0, camd_pc_t'(cpu_req.base[25:0] + cpu_req.disp[25:0])};
		end else begin
			a32 = (cpu_req.use_zero_register ? 32'h0 : cpu_req.base)
				+ {{16{cpu_req.signed_short_offset[15]}}, cpu_req.signed_short_offset};
		end
		phys = a32[27:0];
		tgt  = classify(phys, cpu_req.fetch);
		ahb_take = hsel && htrans[camd_pkg::TRANS_ACT_BIT] && hready;
	end

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.fault = 1'b0;
		s_next.boot_valid = 1'b0;
		s_next.down.valid = 1'b0;
		s_next.cs_n = '1;
		if (!s_reg.strap_done) begin
			s_next.strap_done = 1'b1;
			s_next.busy = 1'b0;
			unique case ({strap_select_high, strap_select_low})
				camd_pkg::STRAP_NORMAL: s_next.mode = camd_pkg::MODE_NORMAL;
				camd_pkg::STRAP_FLASH:  s_next.mode = camd_pkg::MODE_FLASH;
				default:                s_next.mode = camd_pkg::MODE_BAD;
			endcase
			s_next.boot_valid = ({strap_select_high, strap_select_low} == camd_pkg::STRAP_NORMAL);
			s_next.boot_addr  = camd_pkg::RESET_ENTRY;
		end
		unique case (s_reg.st)
			camd_pkg::ST_IDLE: if (acc_go) begin
				s_next.view = cpu_req.fetch ? a32 : {{6{a32[25]}}, a32[25:0]};
				s_next.down.tgt   = tgt;
				s_next.down.write = cpu_req.write;
				s_next.down.size  = cpu_req.size;
				s_next.down.addr  = phys;
				s_next.down.wdata = cpu_req.wdata;
				s_next.down.be    = camd_pkg::BE_BOTH;
				if (tgt == camd_pkg::TGT_NONE || s_reg.mode != camd_pkg::MODE_NORMAL
					|| (tgt == camd_pkg::TGT_EXT && !s_reg.ctrl[camd_pkg::CTRL_EXT_EN_BIT])) begin
					s_next.done = 1'b1;
					s_next.fault = 1'b1;
					s_next.fault_addr = a32;
				end else if (tgt == camd_pkg::TGT_PERI) begin
					s_next.down.valid = 1'b1;
					s_next.word_rd = 1'b0;
					s_next.byte_rd = 1'b0;
					s_next.narrow_rd = cpu_req.byte_wide;
					s_next.hi_lane = phys[0];
					s_next.down.addr = {phys[27:1], 1'b0};
					if (cpu_req.size == camd_pkg::SZ_WORD) begin
						s_next.down.addr  = {phys[27:2], 2'b00};
						s_next.down.size  = camd_pkg::SZ_HALF;
						s_next.down.wdata = {16'h0, cpu_req.wdata[15:0]};
						s_next.hi_wdata   = cpu_req.wdata[31:16];
						s_next.word_rd    = !cpu_req.write;
						s_next.st   = camd_pkg::ST_HI;
						s_next.busy = 1'b1;
					end else begin
						if (cpu_req.size == camd_pkg::SZ_BYTE) begin
							s_next.down.be = phys[0] ? camd_pkg::BE_HIGH : camd_pkg::BE_LOW;
							s_next.byte_rd = 1'b1;
						end else if (cpu_req.byte_wide) begin
							s_next.down.be = camd_pkg::BE_LOW;
						end
						if (cpu_req.write) begin
							s_next.done = 1'b1;
						end else begin
							s_next.st   = camd_pkg::ST_RD_LAST;
							s_next.busy = 1'b1;
						end
					end
				end else begin
					s_next.down.valid = 1'b1;
					s_next.done = 1'b1;
					if (tgt == camd_pkg::TGT_EXT)
						s_next.cs_n = cs_of(phys, s_reg.csc_a, s_reg.csc_b);
				end
			end
			camd_pkg::ST_HI: begin
				s_next.down.valid = 1'b1;
				s_next.down.addr  = s_reg.down.addr + camd_pkg::PERI_HALF_STEP;
				s_next.down.wdata = {16'h0, s_reg.hi_wdata};
				s_next.lo_half    = per_rdata;
				if (s_reg.down.write) begin
					s_next.done = 1'b1;
					s_next.busy = 1'b0;
					s_next.st   = camd_pkg::ST_IDLE;
				end else begin
					s_next.st = camd_pkg::ST_RD_LAST;
				end
			end
			camd_pkg::ST_RD_LAST: begin
				s_next.done = 1'b1;
				s_next.busy = 1'b0;
				s_next.st   = camd_pkg::ST_IDLE;
				if (s_reg.word_rd)
					s_next.rdata = {per_rdata, s_reg.lo_half};
				else if (s_reg.byte_rd)
					s_next.rdata = {24'h0, s_reg.hi_lane ? per_rdata[15:8] : per_rdata[7:0]};
				else if (s_reg.narrow_rd)
					s_next.rdata = {24'h0, per_rdata[7:0]};
				else
					s_next.rdata = {16'h0, per_rdata};
			end
		endcase
		////////////////////////////////////////////////////////////////////////////
		// Register slave; reads take one wait state so data comes from a flop
		if (s_reg.dp_valid && s_reg.dp_wr) begin
			s_next.dp_valid = 1'b0;
			unique case (s_reg.dp_ofs)
				camd_pkg::OFS_CTRL:   s_next.ctrl = hwdata[15:0];
				camd_pkg::OFS_CSC_A:  s_next.csc_a = hwdata[15:0];
				camd_pkg::OFS_CSC_B:  s_next.csc_b = hwdata[15:0];
				camd_pkg::OFS_STATUS: if (hwdata[camd_pkg::STAT_FAULT_BIT])
					s_next.fault_sticky = 1'b0;
				default: ;
			endcase
		end else if (s_reg.dp_valid) begin
			s_next.dp_valid  = 1'b0;
			s_next.hrdata    = reg_read(s_reg, s_reg.dp_ofs);
			s_next.hreadyout = 1'b1;
		end
		if (ahb_take) begin
			s_next.dp_valid  = 1'b1;
			s_next.dp_wr     = hwrite;
			s_next.dp_ofs    = haddr[7:0];
			s_next.hreadyout = hwrite;
		end
		if (s_next.fault)
			s_next.fault_sticky = 1'b1;
		if (srst) begin
			s_next = '0;
			s_next.busy      = 1'b1;
			s_next.csc_a     = camd_pkg::CSC_RESET;
			s_next.csc_b     = camd_pkg::CSC_RESET;
			s_next.cs_n      = '1;
			s_next.hreadyout = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		s_reg <= s_next;
	end

	assign hrdata         = s_reg.hrdata;
	assign hreadyout      = s_reg.hreadyout;
	assign hresp          = 1'b0;
	assign cpu_busy       = s_reg.busy;
	assign cpu_done       = s_reg.done;
	assign cpu_fault      = s_reg.fault;
	assign cpu_rdata      = s_reg.rdata;
	assign cpu_addr_view  = s_reg.view;
	assign boot_valid     = s_reg.boot_valid;
	assign boot_addr      = s_reg.boot_addr;
	assign op_mode        = s_reg.mode;
	assign down           = s_reg.down;
	assign chip_sel_n     = s_reg.cs_n;
	assign ext_bus_enable = s_reg.ctrl[camd_pkg::CTRL_EXT_EN_BIT];

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence seq_word_peri;
		acc_go && tgt == camd_pkg::TGT_PERI && cpu_req.size == camd_pkg::SZ_WORD
			&& s_reg.mode == camd_pkg::MODE_NORMAL;
	endsequence
	sequence seq_two_halves;
		down.valid && down.addr[1:0] == 2'b00 ##1 down.valid && down.addr[1:0] == 2'b10;
	endsequence

	AST_STRAP_MODE: assert property ($rose(s_reg.strap_done) |->
		op_mode == (({strap_select_high, strap_select_low} == camd_pkg::STRAP_NORMAL)
			? camd_pkg::MODE_NORMAL : ({strap_select_high, strap_select_low}
			== camd_pkg::STRAP_FLASH) ? camd_pkg::MODE_FLASH : camd_pkg::MODE_BAD))
		else $error("strap mode wrong");
	AST_BOOT: assert property ($rose(s_reg.strap_done) && op_mode == camd_pkg::MODE_NORMAL
		|-> boot_valid && boot_addr == camd_pkg::RESET_ENTRY)
		else $error("no boot entry");
	AST_SPLIT: assert property (seq_word_peri |-> ##1 seq_two_halves)
		else $error("word split wrong");
	AST_FETCH_PERI: assert property (acc_go && cpu_req.fetch
		&& phys[27:camd_pkg::PAGE_LSB] == camd_pkg::PERI_PAGE |=> cpu_fault && !down.valid)
		else $error("peripheral fetch passed");
	AST_MIRROR: assert property (acc_go
		&& phys[27:camd_pkg::PAGE_LSB] == camd_pkg::MIRROR_PAGE |=> cpu_fault)
		else $error("mirror not refused");
	AST_INTERNAL: assert property (down.valid && down.tgt != camd_pkg::TGT_EXT
		|-> chip_sel_n == '1)
		else $error("internal access made chip select");
	AST_EXT_OFF: assert property (acc_go && !ext_bus_enable && tgt == camd_pkg::TGT_EXT
		|=> cpu_fault && chip_sel_n == '1)
		else $error("external access while disabled");
	AST_ROM_HOLE: assert property (acc_go && phys >= ROM_TOP
		&& phys <= camd_pkg::ROM_REGION_END |=> cpu_fault)
		else $error("rom hole reached");
	AST_RAM_HOLE: assert property (acc_go && phys >= camd_pkg::RAM_REGION_BASE
		&& phys < RAM_BASE |=> cpu_fault)
		else $error("ram hole reached");
	AST_STICKY: assert property (cpu_fault |-> ##[1:2] s_reg.fault_sticky)
		else $error("fault not latched");
	AST_VIEW: assert property (acc_go && !cpu_req.fetch |=>
		cpu_addr_view[31:26] == {6{cpu_addr_view[25]}})
		else $error("data view not extended");
	AST_PC_WRAP: assert property (acc_go && cpu_req.fetch |=>
		cpu_addr_view[31:26] == 6'h0)
		else $error("pc upper bits set");
endmodule // camd_decoder
`default_nettype wire

// ==== src/camd_pkg.sv ====
`default_nettype none
package camd_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// Address map
	localparam int               PHYS_W          = 28;
	localparam int               PC_W            = 26;
	localparam int               PAGE_LSB        = 12;
	localparam logic [15:0]      PERI_PAGE       = 16'hFFFF;
	localparam logic [15:0]      MIRROR_PAGE     = 16'h3FFF;
	localparam logic [27:0]      ROM_REGION_END  = 28'h00FFFFF;
	localparam logic [27:0]      RAM_REGION_BASE = 28'hFFF0000;
	localparam logic [27:0]      RAM_REGION_END  = 28'hFFFEFFF;
	localparam logic [27:0]      EXT_FETCH_LIMIT = 28'h4000000;
	localparam logic [27:0]      PERI_HALF_STEP  = 28'h0000002;
	localparam logic [31:0]      RESET_ENTRY     = 32'h00000000;
	localparam int               ROM_KB_DEF      = 256;
	localparam int               RAM_KB_DEF      = 32;
	localparam int               KB              = 1024;
	////////////////////////////////////////////////////////////////////////////////
	// Chip selects: eight 32 MB blocks, one nibble each
	localparam int               NUM_CS          = 8;
	localparam int               CS_IDX_W        = 3;
	localparam int               CS_BLK_LSB      = 25;
	localparam int               CS_NIB_W        = 4;
	localparam logic [15:0]      CSC_RESET       = 16'h2C11;
	////////////////////////////////////////////////////////////////////////////////
	// Straps, as {high, low}
	localparam logic [1:0]       STRAP_NORMAL    = 2'h0;
	localparam logic [1:0]       STRAP_FLASH     = 2'h2;
	////////////////////////////////////////////////////////////////////////////////
	// Register offsets and fields
	localparam logic [7:0]       OFS_CTRL        = 8'h00;
	localparam logic [7:0]       OFS_CSC_A       = 8'h04;
	localparam logic [7:0]       OFS_CSC_B       = 8'h08;
	localparam logic [7:0]       OFS_STATUS      = 8'h0C;
	localparam logic [7:0]       OFS_FAULT_ADDR  = 8'h10;
	localparam int               CTRL_EXT_EN_BIT = 0;
	localparam int               STAT_READY_BIT  = 2;
	localparam int               STAT_FAULT_BIT  = 8;
	localparam int               TRANS_ACT_BIT   = 1;
	localparam logic [1:0]       BE_BOTH         = 2'h3;
	localparam logic [1:0]       BE_LOW          = 2'h1;
	localparam logic [1:0]       BE_HIGH         = 2'h2;
	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} camd_size_t;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_FLASH, MODE_BAD} camd_mode_t;
	typedef enum logic [2:0] {TGT_NONE, TGT_ROM, TGT_RAM, TGT_PERI, TGT_EXT} camd_tgt_t;
	typedef enum logic [1:0] {ST_IDLE, ST_HI, ST_RD_LAST} camd_fsm_t;

	typedef struct packed {
		logic        fetch;
		logic        write;
		logic        use_zero_register;
		logic        byte_wide;
		camd_size_t  size;
		logic [31:0] base;
		logic [31:0] disp;
		logic [15:0] signed_short_offset;
		logic [31:0] wdata;
	} camd_req_t;

	typedef struct packed {
		logic        valid;
		camd_tgt_t   tgt;
		logic        write;
		camd_size_t  size;
		logic [1:0]  be;
		logic [27:0] addr;
		logic [31:0] wdata;
	} camd_down_t;
endpackage
`default_nettype wire

// ==== tb/camd_periph_model.sv ====
`default_nettype none
module camd_periph_model (
	input  wire logic                 sys_clk,
	input  wire camd_pkg::camd_down_t down,
	output logic [15:0]               per_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	logic        hold_reg = 1'h0;
	logic [15:0] last_reg = 16'h0F0F;
	logic        rd_now;
	function automatic logic [15:0] pat(input logic [27:0] a);
		return {~a[7:0], a[7:0]};
	endfunction
	assign rd_now = down.valid === 1'h1 && down.tgt == camd_pkg::TGT_PERI && !down.write;
	always @(posedge sys_clk) begin
		hold_reg <= rd_now;
		if (rd_now)
			last_reg <= pat(down.addr);
		else if (!hold_reg)
			last_reg <= ~last_reg;
	end
	// Released bus holds the last read data for one cycle, then toggles each cycle
	assign per_rdata = rd_now ? pat(down.addr) : (hold_reg ? last_reg : ~last_reg);
endmodule // camd_periph_model
`default_nettype wire

// ==== tb/camd_decoder_bench.sv ====
`default_nettype none
module camd_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam camd_pkg::camd_tgt_t  ROM = camd_pkg::TGT_ROM;
	localparam camd_pkg::camd_tgt_t  RAM = camd_pkg::TGT_RAM;
	localparam camd_pkg::camd_tgt_t  PER = camd_pkg::TGT_PERI;
	localparam camd_pkg::camd_tgt_t  EXT = camd_pkg::TGT_EXT;
	localparam camd_pkg::camd_size_t HW  = camd_pkg::SZ_HALF;
	localparam camd_pkg::camd_size_t WD  = camd_pkg::SZ_WORD;
	logic                  sys_clk = 1'h0;
	logic                  srst = 1'h1;
	logic                  s_lo = 1'h0;
	logic                  s_hi = 1'h0;
	logic                  hsel = 1'h0;
	logic                  hwrite = 1'h0;
	logic [1:0]            htrans = 2'h0;
	logic [31:0]           haddr = 32'h0;
	logic [31:0]           hwdata = 32'h0;
	logic [31:0]           hrdata, cpu_rdata, cpu_addr_view, boot_addr, rd;
	logic                  hreadyout, hresp, cpu_busy, cpu_done, cpu_fault, boot_valid;
	logic                  cpu_req_valid = 1'h0;
	logic                  ext_bus_enable;
	logic                  boot_seen = 1'h0;
	camd_pkg::camd_req_t   cpu_req = '0;
	camd_pkg::camd_mode_t  op_mode;
	camd_pkg::camd_down_t  down;
	logic [15:0]           per_rdata;
	logic [7:0]            chip_sel_n, cs;
	logic [27:0]           pa0;
	camd_pkg::camd_tgt_t   tg0;
	int                    n_fail = 0;
	int                    checks_done = 0;
	int                    nv;
	////////////////////////////////////////////////////////////////////////////////
	camd_decoder dut (.sys_clk(sys_clk), .srst(srst), .strap_select_low(s_lo),
		.strap_select_high(s_hi), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req), .cpu_busy(cpu_busy),
		.cpu_done(cpu_done), .cpu_fault(cpu_fault), .cpu_rdata(cpu_rdata),
		.cpu_addr_view(cpu_addr_view), .boot_valid(boot_valid), .boot_addr(boot_addr),
		.op_mode(op_mode), .down(down), .per_rdata(per_rdata),
		.chip_sel_n(chip_sel_n), .ext_bus_enable(ext_bus_enable));
	camd_periph_model peri (.sys_clk(sys_clk), .down(down), .per_rdata(per_rdata));
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (srst)
			boot_seen <= 1'h0;
		else if (boot_valid === 1'h1 && boot_addr === camd_pkg::RESET_ENTRY)
			boot_seen <= 1'h1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Straps only move while reset is held
	task automatic do_reset(input logic [1:0] st);
		srst <= 1'h1;
		@(posedge sys_clk);
		{s_hi, s_lo} <= st;
		repeat (7) @(posedge sys_clk);
		srst <= 1'h0;
		do begin
			@(posedge sys_clk);
		end while (cpu_busy !== 1'h0);
		repeat (2) @(posedge sys_clk);
	endtask
	// Waits end only when hreadyout is high; a hang is left to the watchdog
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do begin
			@(posedge sys_clk);
		end while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge sys_clk);
		end while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic access(input logic f, zr, wr, bw, input camd_pkg::camd_size_t sz,
			input logic [31:0] b, d, input logic flt, input camd_pkg::camd_tgt_t tg,
			input logic [27:0] pa, input logic [31:0] vw);
		int n;
		camd_pkg::camd_req_t r;
		r = '0;
		r.fetch = f;
		r.write = wr;
		r.use_zero_register = zr;
		r.byte_wide = bw;
		r.size = sz;
		r.base = b;
		r.disp = d;
		r.signed_short_offset = d[15:0];
		r.wdata = 32'hA5C30F96;
		n = 0;
		nv = 0;
		cpu_req <= r;
		cpu_req_valid <= 1'h1;
		do begin @(posedge sys_clk); n++; end while (cpu_busy !== 1'h0 && n < 50);
		cpu_req_valid <= 1'h0;
		do begin
			@(posedge sys_clk);
			n++;
			if (down.valid === 1'h1) begin
				if (nv == 0) begin
					pa0 = down.addr;
					tg0 = down.tgt;
					cs = chip_sel_n;
				end
				nv++;
			end
		end while (cpu_done !== 1'h1 && n < 60);
		// A lost answer counts as a mismatch here
		chk("done", {31'h0, cpu_done}, 32'h1);
		chk("fault", {31'h0, cpu_fault}, {31'h0, flt});
		if (flt) begin
			chk("suppressed", nv, 32'h0);
		end else begin
			chk("target", {31'h0, pa0 == pa}, 32'h1);
			chk("route", {29'h0, tg0}, {29'h0, tg});
			chk("view", cpu_addr_view, vw);
			if (tg != EXT)
				chk("cs_internal", {24'h0, cs}, 32'hFF);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole run needs about a hundred cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		complete_run();
	end
	// Only the refusal scenario branches into the mirror; no DMA here
	initial begin
		do_reset(2'h0);
		chk("mode", {30'h0, op_mode}, {30'h0, camd_pkg::MODE_NORMAL});
		chk("boot", {31'h0, boot_seen}, 32'h1);
		chk("ext_en", {31'h0, ext_bus_enable}, 32'h0);
		ahb(1'h0, camd_pkg::OFS_CSC_B, 32'h0);
		chk("csc_b", rd, 32'h2C11);
		ahb(1'h0, 8'h14, 32'h0);
		chk("unmapped", rd, 32'h0);
		access(0, 1, 0, 0, WD, 32'hDEADBEEF, 32'h8000, 0, RAM, 28'hFFF8000, 32'hFFFF8000);
		access(0, 0, 0, 0, WD, 32'h00001000, 32'h0010, 0, ROM, 28'h0001010, 32'h1010);
		access(0, 0, 0, 0, WD, 32'h3003FFF0, 32'h000F, 0, ROM, 28'h003FFFF, 32'h3FFFF);
		access(0, 0, 0, 0, WD, 32'h00040000, 32'h0, 1, ROM, 28'h0, 32'h0);
		access(0, 0, 0, 0, WD, 32'h0FFF6FFC, 32'h0, 1, RAM, 28'h0, 32'h0);
		access(0, 0, 0, 0, WD, 32'h0FFF7000, 32'h0, 0, RAM, 28'hFFF7000, 32'hFFFF7000);
		access(0, 0, 0, 0, WD, 32'hFFFFFFF0, 32'h0020, 0, ROM, 28'h0000010, 32'h10);
		access(1, 0, 0, 0, WD, 32'h03FFFFFC, 32'h8, 0, ROM, 28'h0000004, 32'h4);
		access(1, 0, 0, 0, WD, 32'h0FFFF000, 32'h0, 1, PER, 28'h0, 32'h0);
		access(0, 0, 0, 0, WD, 32'h03FFF000, 32'h0, 1, PER, 28'h0, 32'h0);
		ahb(1'h0, camd_pkg::OFS_FAULT_ADDR, 32'h0);
		chk("fault_addr", rd, 32'h03FFF000);
		ahb(1'h0, camd_pkg::OFS_STATUS, 32'h0);
		chk("status", rd & 32'h107, 32'h104);
		ahb(1'h1, camd_pkg::OFS_STATUS, 32'h100);
		ahb(1'h0, camd_pkg::OFS_STATUS, 32'h0);
		chk("fault_clr", rd & 32'h100, 32'h0);
		access(0, 0, 0, 0, WD, 32'h0FFFF062, 32'h0, 0, PER, 28'hFFFF060, 32'hFFFFF062);
		chk("halves", nv, 32'h2);
		chk("word", cpu_rdata, 32'h9D629F60);
		access(0, 0, 1, 0, WD, 32'h0FFFF060, 32'h0, 0, PER, 28'hFFFF060, 32'hFFFFF060);
		chk("wr_halves", nv, 32'h2);
		access(0, 0, 0, 1, HW, 32'h0FFFF010, 32'h0, 0, PER, 28'hFFFF010, 32'hFFFFF010);
		chk("byte_reg", {16'h0, cpu_rdata[15:0]}, 32'h0010);
		// External space stays shut until software opens it
		access(0, 0, 0, 0, WD, 32'h01000000, 32'h0, 1, EXT, 28'h0, 32'h0);
		ahb(1'h1, camd_pkg::OFS_CTRL, 32'h1);
		// The write lands on the edge that ends the data phase
		@(posedge sys_clk);
		chk("ext_on", {31'h0, ext_bus_enable}, 32'h1);
		access(0, 0, 0, 0, WD, 32'h01000000, 32'h0, 0, EXT, 28'h1000000, 32'h01000000);
		chk("cs_blk0", {24'h0, cs}, 32'hFD);
		access(1, 0, 0, 0, WD, 32'h01000000, 32'h0, 0, EXT, 28'h1000000, 32'h01000000);
		// Bits 25:0 clear, so the data view of this address is zero
		access(0, 0, 0, 0, WD, 32'h0C000000, 32'h0, 0, EXT, 28'hC000000, 32'h00000000);
		chk("cs_blk6", {24'h0, cs}, 32'hEF);
		ahb(1'h1, camd_pkg::OFS_CSC_A, 32'h5);
		access(0, 0, 0, 0, WD, 32'h01000000, 32'h0, 0, EXT, 28'h1000000, 32'h01000000);
		chk("cs_remap", {24'h0, cs}, 32'hDF);
		access(0, 0, 0, 0, WD, 32'h00000100, 32'h0, 0, ROM, 28'h0000100, 32'h100);
		do_reset(2'h1);
		chk("mode_bad", {30'h0, op_mode}, {30'h0, camd_pkg::MODE_BAD});
		chk("no_boot", {31'h0, boot_seen}, 32'h0);
		access(0, 0, 0, 0, WD, 32'h00000100, 32'h0, 1, ROM, 28'h0, 32'h0);
		do_reset(2'h2);
		chk("mode_flash", {30'h0, op_mode}, {30'h0, camd_pkg::MODE_FLASH});
		complete_run();
	end
endmodule // camd_decoder_bench
`default_nettype wire
